// ### design/frs_sequencer.sv
// fire service recall sequencer with apb register access.
// assumes car position and stop status from the lift controller, and
// contact inputs that are slow and synchronous-free (they get filtered).
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "frs_params.svh"

module frs_sequencer #(
  parameter int unsigned DEB_CYC = `FRS_DEB_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // contacts and car status
  input frs_pkg::frs_contacts_t contacts,
  input frs_pkg::frs_car_t car,
  // commands to the lift controller
  output frs_pkg::frs_out_t cmd
);
  import frs_pkg::*;

  typedef struct packed {
    frs_state_t st;
    logic en;
    frs_variant_t variant;
    logic [2:0] nc;
    logic [`FRS_FLOOR_W-1:0] floor;
    logic [`FRS_ACC_W-1:0] access;
    logic lk_prev;
    logic [31:0] prdata;
    frs_out_t out;
  } frs_reg_t;

  localparam frs_out_t OUT_RST = '{
    landing_panel_en: 1'b1,
    car_panel_en: 1'b1,
    target_floor: `FRS_FLOOR_RST,
    door_access: `FRS_ACC_RST,
    default: '0
  };
  localparam frs_reg_t REG_RST = '{
    st: FRS_ST_IDLE,
    en: `FRS_EN_RST,
    variant: frs_variant_t'(`FRS_VAR_RST),
    nc: `FRS_NC_RST,
    floor: `FRS_FLOOR_RST,
    access: `FRS_ACC_RST,
    lk_prev: 1'b0,
    prdata: 32'h0000_0000,
    out: OUT_RST
  };

  frs_reg_t q;
  frs_reg_t d;
  logic [2:0] filt;
  logic [2:0] act;
  logic lk;
  logic ck;
  logic fd;
  logic at_recall;
  logic trigger;
  logic release_ok;
  logic car_ok;
  logic access_ph;
  logic mapped;
  logic [31:0] ctrl_rd;
  logic [31:0] cfg_rd;
  logic [31:0] stat_rd;

  // ****************************************
  // contact conditioning
  // ****************************************
  frs_debounce #(
    .N(3),
    .CYC(DEB_CYC)
  ) u_deb (
    .clk(clk),
    .rst_b(rst_b),
    .raw(contacts),
    .filt(filt)
  );

  assign act = filt ^ q.nc;
  assign lk = act[0];
  assign ck = act[1];
  assign fd = act[2];
  assign at_recall = car.car_stopped && (car.car_floor == q.floor);

  // ****************************************
  // variant decode
  // ****************************************
  always_comb begin
    trigger = 1'b0;
    release_ok = 1'b0;
    car_ok = 1'b0;
    case (q.variant)
      FRS_V_SINGLE: begin
        trigger = lk;
        release_ok = !lk;
        car_ok = 1'b1;
      end
      FRS_V_DUAL: begin
        trigger = lk;
        release_ok = !lk && !ck;
        car_ok = ck;
      end
      FRS_V_EXT1: begin
        // the fire contact is wired onto the car key input here
        trigger = ck;
        release_ok = !lk && !ck;
        car_ok = lk;
      end
      FRS_V_EXT2: begin
        trigger = fd || lk;
        release_ok = !lk && !ck && !fd;
        car_ok = ck;
      end
      FRS_V_EMER: begin
        trigger = fd;
        release_ok = !lk && !ck && !fd;
        car_ok = ck;
      end
      default: begin
        trigger = 1'b0;
      end
    endcase
  end

  // ****************************************
  // register views
  // ****************************************
  always_comb begin
    ctrl_rd = '0;
    ctrl_rd[`FRS_CTRL_EN] = q.en;
    ctrl_rd[`FRS_CTRL_VAR_LSB +: 3] = q.variant;
    ctrl_rd[`FRS_CTRL_NC_LSB +: 3] = q.nc;
    cfg_rd = '0;
    cfg_rd[`FRS_CFG_FLOOR_LSB +: `FRS_FLOOR_W] = q.floor;
    cfg_rd[`FRS_CFG_ACC_LSB +: `FRS_ACC_W] = q.access;
    stat_rd = '0;
    stat_rd[`FRS_STAT_ST_LSB +: 3] = q.st;
    stat_rd[`FRS_STAT_ACT_LSB +: 3] = act;
    stat_rd[`FRS_STAT_FIRE] = q.out.fire_active;
  end

  assign mapped = (paddr == `FRS_OFF_CTRL) || (paddr == `FRS_OFF_CFG) ||
                  (paddr == `FRS_OFF_STAT);
  assign access_ph = psel && penable;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    d = q;
    d.out.cancel_calls = 1'b0;
    d.out.em_call_valid = 1'b0;
    d.lk_prev = lk;
    // read data is captured in setup so it comes from a flop in access
    if (psel && !penable) begin
      if (paddr == `FRS_OFF_CTRL) begin
        d.prdata = ctrl_rd;
      end else if (paddr == `FRS_OFF_CFG) begin
        d.prdata = cfg_rd;
      end else if (paddr == `FRS_OFF_STAT) begin
        d.prdata = stat_rd;
      end else begin
        d.prdata = '0;
      end
    end
    if (access_ph && pwrite) begin
      if (paddr == `FRS_OFF_CTRL) begin
        d.en = pwdata[`FRS_CTRL_EN];
        d.variant = frs_variant_t'(pwdata[`FRS_CTRL_VAR_LSB +: 3]);
        d.nc = pwdata[`FRS_CTRL_NC_LSB +: 3];
      end else if (paddr == `FRS_OFF_CFG) begin
        d.floor = pwdata[`FRS_CFG_FLOOR_LSB +: `FRS_FLOOR_W];
        d.access = pwdata[`FRS_CFG_ACC_LSB +: `FRS_ACC_W];
      end
    end
    case (q.st)
      FRS_ST_IDLE: begin
        if (q.en && trigger) begin
          d.st = FRS_ST_RECALL;
          // only the emergency variant throws away waiting calls
          d.out.cancel_calls = (q.variant == FRS_V_EMER);
        end
      end
      FRS_ST_RECALL: begin
        if (!q.en) begin
          d.st = FRS_ST_IDLE;
        end else if (at_recall && release_ok) begin
          d.st = FRS_ST_IDLE;
        end else if (at_recall) begin
          d.st = FRS_ST_PARKED;
        end
      end
      FRS_ST_PARKED: begin
        // firefighters may drive away; the end waits for the recall floor
        if (!q.en || (at_recall && release_ok)) begin
          d.st = FRS_ST_IDLE;
        end
        if (q.variant == FRS_V_EMER && lk && !q.lk_prev && !ck) begin
          d.out.em_call_valid = 1'b1;
          d.out.em_call_floor = car.key_floor;
        end
      end
      default: begin
        d.st = FRS_ST_IDLE;
      end
    endcase
    // outputs follow the next state so they line up with the state flop
    d.out.fire_active = (d.st != FRS_ST_IDLE);
    d.out.recall_req = (d.st == FRS_ST_RECALL);
    d.out.target_floor = d.floor;
    d.out.door_access = d.access;
    d.out.door_open = d.out.fire_active && at_recall;
    if (d.st == FRS_ST_IDLE) begin
      d.out.landing_panel_en = 1'b1;
      d.out.car_panel_en = 1'b1;
      d.out.car_calls_block = 1'b0;
    end else begin
      d.out.landing_panel_en = 1'b0;
      // during the run to the recall floor the emergency car panel is dead
      d.out.car_panel_en = car_ok &&
        !(q.variant == FRS_V_EMER && d.st == FRS_ST_RECALL);
      d.out.car_calls_block = !d.out.car_panel_en;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= REG_RST;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign prdata = q.prdata;
  assign pready = access_ph;
  assign pslverr = access_ph && !mapped;
  assign cmd = q.out;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_idle_pol;
    (q.st == FRS_ST_IDLE) && (q.variant == FRS_V_SINGLE) &&
      (filt[0] == q.nc[0]) |=> !q.out.fire_active;
  endproperty
  a_idle_pol: assert property (p_idle_pol)
    else $error("activation does not follow idle polarity");

  property p_floor;
    access_ph && pwrite && (paddr == `FRS_OFF_CFG)
      |=> q.out.target_floor ==
          $past(pwdata[`FRS_CFG_FLOOR_LSB +: `FRS_FLOOR_W]);
  endproperty
  a_floor: assert property (p_floor)
    else $error("target floor differs from recall floor");

  sequence s_start;
    (q.st == FRS_ST_IDLE) && q.en && trigger;
  endsequence
  property p_start;
    s_start |=> q.out.recall_req && !q.out.landing_panel_en;
  endproperty
  a_start: assert property (p_start)
    else $error("trigger did not start recall");

  property p_hold;
    (q.st != FRS_ST_IDLE) && q.en && !(at_recall && release_ok)
      |=> q.out.fire_active;
  endproperty
  a_hold: assert property (p_hold)
    else $error("fire operation ended early");

  sequence s_nocar;
    (q.st == FRS_ST_PARKED) && !car_ok ##1 (q.st == FRS_ST_PARKED);
  endsequence
  property p_nocar;
    s_nocar |-> q.out.car_calls_block && !q.out.car_panel_en;
  endproperty
  a_nocar: assert property (p_nocar)
    else $error("car panel usable without its key");

  property p_ext1;
    (q.variant == FRS_V_EXT1) && $rose(q.out.fire_active)
      |-> $past(ck);
  endproperty
  a_ext1: assert property (p_ext1)
    else $error("contact variant started without contact");

  property p_cancel;
    (s_start and (q.variant == FRS_V_EMER))
      |=> q.out.cancel_calls && !q.out.car_panel_en ##1 !q.out.cancel_calls;
  endproperty
  a_cancel: assert property (p_cancel)
    else $error("emergency entry did not cancel calls");

  property p_emcall;
    q.out.em_call_valid |-> $past(!ck) && $past(lk) && !$past(q.lk_prev);
  endproperty
  a_emcall: assert property (p_emcall)
    else $error("landing call placed with car key active");

  property p_end;
    $fell(q.out.fire_active) && $past(q.en)
      |-> $past(at_recall) && $past(release_ok);
  endproperty
  a_end: assert property (p_end)
    else $error("fire operation ended away from recall floor");

  property p_deb;
    $changed(filt) |=> $stable(filt);
  endproperty
  a_deb: assert property (p_deb)
    else $error("filtered contact toggled on consecutive cycles");

endmodule

// ### design/frs_params.svh
// constants of the fire service recall sequencer: offsets, fields, resets,
// timing. assumes a 50 MHz system clock.
`ifndef FRS_PARAMS_SVH
`define FRS_PARAMS_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define FRS_OFF_CTRL 12'h000
`define FRS_OFF_CFG 12'h004
`define FRS_OFF_STAT 12'h008

// ****************************************
// field positions
// ****************************************
`define FRS_CTRL_EN 0
`define FRS_CTRL_VAR_LSB 1
`define FRS_CTRL_NC_LSB 4
`define FRS_CFG_FLOOR_LSB 0
`define FRS_CFG_ACC_LSB 8
`define FRS_STAT_ST_LSB 0
`define FRS_STAT_ACT_LSB 3
`define FRS_STAT_FIRE 6

// ****************************************
// widths and reset values
// ****************************************
`define FRS_FLOOR_W 6
`define FRS_ACC_W 2
`define FRS_EN_RST 1'b0
`define FRS_VAR_RST 3'h0
`define FRS_NC_RST 3'h0
`define FRS_FLOOR_RST 6'h00
`define FRS_ACC_RST 2'h1

// ****************************************
// timing
// ****************************************
`define FRS_CLK_MHZ 50
`define FRS_DEB_TIME_US 1000
`define FRS_DEB_CYC (`FRS_DEB_TIME_US * `FRS_CLK_MHZ)

`endif

// ### design/frs_pkg.sv
// types of the fire service recall sequencer.
// assumes frs_params.svh is on the include path.
`include "frs_params.svh"

package frs_pkg;

  typedef enum logic [2:0] {
    FRS_ST_IDLE = 3'h1,
    FRS_ST_RECALL = 3'h2,
    FRS_ST_PARKED = 3'h4
  } frs_state_t;

  typedef enum logic [2:0] {
    FRS_V_SINGLE = 3'h0,
    FRS_V_DUAL = 3'h1,
    FRS_V_EXT1 = 3'h2,
    FRS_V_EXT2 = 3'h3,
    FRS_V_EMER = 3'h4
  } frs_variant_t;

  // contacts in channel order: landing key, car key, fire detect
  typedef struct packed {
    logic fire_detect_input;
    logic car_key_input;
    logic landing_key_input;
  } frs_contacts_t;

  typedef struct packed {
    logic [`FRS_FLOOR_W-1:0] car_floor;
    logic car_stopped;
    logic [`FRS_FLOOR_W-1:0] key_floor;
  } frs_car_t;

  typedef struct packed {
    logic fire_active;
    logic recall_req;
    logic [`FRS_FLOOR_W-1:0] target_floor;
    logic [`FRS_ACC_W-1:0] door_access;
    logic door_open;
    logic landing_panel_en;
    logic car_panel_en;
    logic car_calls_block;
    logic cancel_calls;
    logic em_call_valid;
    logic [`FRS_FLOOR_W-1:0] em_call_floor;
  } frs_out_t;

endpackage

// ### design/frs_debounce.sv
// per-channel synchroniser and bounce filter for contact inputs.
// assumes contacts are slow mechanical levels; cyc of at least 2.
`timescale 1ns/1ps

module frs_debounce #(
  parameter int unsigned N = 3,
  parameter int unsigned CYC = 50000
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // contacts
  input wire logic [N-1:0] raw,
  output logic [N-1:0] filt
);
  import frs_pkg::*;

  localparam int unsigned CW = $clog2(CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(CYC - 1);

  typedef struct packed {
    logic [N-1:0] s1;
    logic [N-1:0] s2;
    logic [N-1:0] filt;
    logic [N-1:0][CW-1:0] cnt;
  } frs_deb_t;

  frs_deb_t q;
  frs_deb_t d;

  always_comb begin
    d = q;
    d.s1 = raw;
    d.s2 = q.s1;
    for (int i = 0; i < N; i++) begin
      // a change must hold for the whole window; any bounce restarts it
      if (q.s2[i] != q.filt[i]) begin
        if (q.cnt[i] == LAST) begin
          d.filt[i] = q.s2[i];
          d.cnt[i] = '0;
        end else begin
          d.cnt[i] = q.cnt[i] + CW'(1);
        end
      end else begin
        d.cnt[i] = '0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign filt = q.filt;

endmodule

// ### dv/frs_contact_model.sv
// partner model: landing key, car key and fire detect contact.
// assumes act is the wanted activation per channel, nc the idle wiring.
`timescale 1ns/1ps

// ****************************************
// contact model
// ****************************************
module frs_contact_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // wanted state
  input wire logic [2:0] act,
  input wire logic [2:0] nc,
  // contact levels
  output frs_pkg::frs_contacts_t raw
);
  import frs_pkg::*;
  logic [2:0] prev;
  logic [2:0] mask;
  logic [2:0] bcnt;
  // every change chatters for five cycles, like a real key
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prev <= 3'h0;
      mask <= 3'h0;
      bcnt <= 3'h0;
      raw <= nc;
    end else begin
      prev <= act;
      if (act !== prev) begin
        mask <= act ^ prev;
        bcnt <= 3'h5;
      end else if (bcnt != 3'h0) begin
        bcnt <= bcnt - 3'h1;
      end
      if (bcnt != 3'h0) begin
        raw <= raw ^ mask;
      end else begin
        // idle level set by wiring; activation leaves it
        raw <= nc ^ act;
      end
    end
  end
endmodule

// ### dv/test_fire_service_recall_sequencer.sv
// self-checking bench of the fire service recall sequencer.
// assumes the contact model in dv and a short debounce window.
`timescale 1ns/1ps
`include "frs_params.svh"

module test_fire_service_recall_sequencer;
  import frs_pkg::*;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] act, nc, trig;
  logic [5:0] flr, em_flr;
  logic [1:0] acc;
  frs_contacts_t contacts;
  frs_car_t car;
  frs_out_t cmd, e;
  int mismatches, tests_run, seed, cyc, cc_cnt, em_cnt, cc0, em0, v;

  frs_sequencer #(.DEB_CYC(4)) frs_sequencer_i (.clk(clk), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .contacts(contacts), .car(car), .cmd(cmd));
  frs_contact_model frs_contact_model_i (.clk(clk), .rst_b(rst_b),
    .act(act), .nc(nc), .raw(contacts));

  // ****************************************
  // clock, pulse monitors, timeout
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cmd.cancel_calls === 1'b1) begin
      cc_cnt <= cc_cnt + 1;
    end
    if (cmd.em_call_valid === 1'b1) begin
      em_cnt <= em_cnt + 1;
      em_flr <= cmd.em_call_floor;
    end
    if (cyc == 5000) begin
      mismatches = mismatches + 1;
      close_out();
    end
  end

  // ****************************************
  // tasks and expectations
  // ****************************************
  task close_out;
    if (mismatches == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] x);
    tests_run = tests_run + 1;
    if (seen !== x) begin
      mismatches = mismatches + 1;
      $display("BAD %s exp %h seen %h", nm, x, seen);
    end
  endtask

  // slave has no wait states, but pready is still waited for
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches = mismatches + 1;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic rel(input int v, input logic [2:0] a);
    case (v)
      0: rel = !a[0];
      1, 2: rel = (a[1:0] == 2'b00);
      default: rel = (a == 3'b000);
    endcase
  endfunction

  function automatic logic cp_exp(input int v, input logic [2:0] a,
                                  input logic p);
    case (v)
      0: cp_exp = 1'b1;
      1, 3: cp_exp = a[1];
      2: cp_exp = a[0];
      default: cp_exp = p & a[1];
    endcase
  endfunction

  // settle covers chatter, two sync stages and the filter window
  task look(input logic p);
    logic f, cp;
    logic [2:0] st;
    repeat (20) @(posedge clk);
    f = p ? !rel(v, act) : 1'b1;
    cp = f ? cp_exp(v, act, p) : 1'b1;
    st = !f ? 3'h1 : (p ? 3'h4 : 3'h2);
    chk("fire", cmd.fire_active, f);
    chk("recall", cmd.recall_req, f & !p);
    chk("door", cmd.door_open, f & p);
    chk("lpanel", cmd.landing_panel_en, !f);
    chk("cpanel", cmd.car_panel_en, cp);
    chk("block", cmd.car_calls_block, f & !cp);
    chk("target", cmd.target_floor, flr);
    chk("access", cmd.door_access, acc);
    apb(1'b0, `FRS_OFF_STAT, 32'h0);
    chk("stat", rd, {25'h0, f, act, st});
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rst_b = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    act = 3'h0;
    nc = 3'h0;
    car = '0;
    seed = 32'ha59b;
    {mismatches, tests_run, cyc, cc_cnt, em_cnt} = '0;
    flr = 6'h00;
    acc = 2'h1;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    e = '0;
    e.landing_panel_en = 1'b1;
    e.car_panel_en = 1'b1;
    e.door_access = 2'h1;
    @(posedge clk);
    chk("cmd_rst", cmd, e);
    apb(1'b0, `FRS_OFF_CFG, 32'h0);
    chk("cfg_rst", rd, 32'h100);
    apb(1'b0, 12'h00C, 32'h0);
    chk("unmapped_err", err, 1'b1);
    chk("unmapped_rd", rd, 32'h0);
    apb(1'b1, `FRS_OFF_STAT, 32'hFF);
    apb(1'b0, `FRS_OFF_STAT, 32'h0);
    chk("stat_ro", rd, 32'h1);
    for (v = 0; v < 5; v++) begin
      flr = 6'($random(seed));
      acc = 2'($random(seed));
      // idle wiring changes only while disabled, so no false trigger
      apb(1'b1, `FRS_OFF_CTRL, {25'h0, nc, 3'(v), 1'b0});
      nc <= 3'($random(seed));
      @(posedge clk);
      apb(1'b1, `FRS_OFF_CTRL, {25'h0, nc, 3'(v), 1'b0});
      repeat (20) @(posedge clk);
      apb(1'b1, `FRS_OFF_CTRL, {25'h0, nc, 3'(v), 1'b1});
      apb(1'b1, `FRS_OFF_CFG, {22'h0, acc, 2'h0, flr});
      apb(1'b0, `FRS_OFF_CFG, 32'h0);
      chk("cfg", rd, {22'h0, acc, 2'h0, flr});
      car <= '{car_floor: flr ^ 6'h01, car_stopped: 1'b1,
               key_floor: 6'($random(seed))};
      trig = (v < 2) ? 3'b001 : ((v == 2) ? 3'b010 : 3'b100);
      cc0 = cc_cnt;
      act <= trig;
      look(1'b0);
      chk("cancel", cc_cnt - cc0, v == 4);
      car.car_floor <= flr;
      look(1'b1);
      act <= act | 3'b011;
      look(1'b1);
      act <= act & 3'b101;
      look(1'b1);
      em0 = em_cnt;
      if (v >= 3) begin
        act <= act & 3'b110;
        look(1'b1);
        act <= act | 3'b001;
        look(1'b1);
      end
      chk("em_call", em_cnt - em0, v == 4);
      if (v == 4) begin
        chk("em_floor", em_flr, car.key_floor);
      end
      act <= (v >= 3) ? 3'b100 : 3'b010;
      look(1'b1);
      act <= 3'b000;
      look(1'b1);
    end
    // undefined variant code must never start a fire operation
    apb(1'b1, `FRS_OFF_CTRL, {25'h0, nc, 3'h5, 1'b1});
    act <= 3'b111;
    repeat (20) @(posedge clk);
    chk("bad_variant", cmd.fire_active, 1'b0);
    apb(1'b1, `FRS_OFF_CTRL, {25'h0, nc, 3'h4, 1'b1});
    repeat (4) @(posedge clk);
    chk("abort_pre", cmd.fire_active, 1'b1);
    // clearing the enable aborts a running fire operation
    apb(1'b1, `FRS_OFF_CTRL, {25'h0, nc, 3'h4, 1'b0});
    repeat (2) @(posedge clk);
    chk("abort", cmd.fire_active, 1'b0);
    close_out();
  end
endmodule
